// >>> logic/sram_ctrl.sv
// Host-side controller sequencing a 32K x 8 asynchronous static memory.
// Assumes the memory strobes are wired straight to the pin outputs.
//
// Contract
// RULE1: Memory holds 32768 bytes, 15-bit address
// RULE2: Select and write low store bus byte
// RULE3: Select, output enable low read drives
// RULE4: Memory drives only when reading
// RULE5: Select high means standby, strobes ignored
// RULE6: Write lasts exactly the strobe overlap
// RULE7: Write starts both low, ends either rising
// RULE8: Data setup referenced to ending strobe
// RULE9: Write cycle at least float plus setup
// RULE10: Drive data only after memory floats
// RULE11: Memory floats while output enable high
// RULE12: Simultaneous strobe rise keeps bus floating
// RULE13: Address valid by select falling edge
// RULE14: Memory contents undefined until written
`timescale 1ns/1ps
module sram_ctrl (
  input  wire logic                               sys_clk_in,
  input  wire logic                               srst_in,
  input  wire logic                               req_valid_in,
  input  wire logic                               req_write_in,
  input  wire logic [sram_ctrl_pkg::ADDR_W-1:0]   req_addr_in,
  input  wire logic [sram_ctrl_pkg::DATA_W-1:0]   req_wdata_in,
  output logic                                    req_ready_out,
  output logic                                    rd_valid_out,
  output logic [sram_ctrl_pkg::DATA_W-1:0]        rd_data_out,
  output logic [sram_ctrl_pkg::ADDR_W-1:0]        address_bus_out,
  output logic                                    select_n_out,
  output logic                                    write_en_n_out,
  output logic                                    out_en_n_out,
  input  wire logic [sram_ctrl_pkg::DATA_W-1:0]   data_bus_in,
  output logic [sram_ctrl_pkg::DATA_W-1:0]        data_bus_out,
  output logic                                    data_bus_oe_n_out
);
  import sram_ctrl_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Pin input synchroniser, three stages
  logic [DATA_W-1:0] sync1_q;
  logic [DATA_W-1:0] sync2_q;
  logic [DATA_W-1:0] sync3_q;
  logic [DATA_W-1:0] stable_q;

  always_ff @(posedge sys_clk_in) begin
    sync1_q <= data_bus_in;
    sync2_q <= sync1_q;
    sync3_q <= sync2_q;
  end

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      stable_q <= '0;
    end else if (sync2_q == sync3_q) begin
      stable_q <= sync3_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer
  ctrl_state_t       state_q;
  logic [CNT_W-1:0]  cnt_q;
  logic              write_q;

  function automatic logic [CNT_W-1:0] cyc(input int unsigned n);
    cyc = CNT_W'(n - 1);
  endfunction

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      state_q <= ST_IDLE;
      cnt_q   <= '0;
      write_q <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (req_valid_in) begin
            write_q <= req_write_in;
            if (req_write_in) begin
              state_q <= ST_WR_FLOAT;
              cnt_q   <= cyc(FLOAT_CYC);
            end else begin
              state_q <= ST_RD_STROBE;
              cnt_q   <= cyc(READ_CYC + 3);
            end
          end
        end
        ST_RD_STROBE: begin
          if (cnt_q == '0) begin
            state_q <= ST_RECOVER;
            cnt_q   <= cyc(RECOVER_CYC);
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        ST_WR_FLOAT: begin
          if (cnt_q == '0) begin
            state_q <= ST_WR_DRIVE;
            cnt_q   <= cyc(WRITE_CYC - FLOAT_CYC);
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        ST_WR_DRIVE: begin
          if (cnt_q == '0) begin
            state_q <= ST_WR_END;
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        ST_WR_END: begin
          state_q <= ST_IDLE;
        end
        ST_RECOVER: begin
          if (cnt_q == '0) begin
            state_q <= ST_IDLE;
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Address and strobe pins
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      address_bus_out <= '0;
    end else if (state_q == ST_IDLE && req_valid_in) begin
      address_bus_out <= req_addr_in; // RULE13 RULE1
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      select_n_out   <= 1'b1;
      write_en_n_out <= 1'b1;
      out_en_n_out   <= 1'b1;
    end else begin
      // Select falls one cycle after the address settles
      select_n_out   <= !(state_q == ST_RD_STROBE || state_q == ST_WR_FLOAT
                          || state_q == ST_WR_DRIVE); // RULE13 RULE5
      // Both strobes rise together to end the write
      write_en_n_out <= !(state_q == ST_WR_FLOAT || state_q == ST_WR_DRIVE); // RULE7 RULE6
      out_en_n_out   <= !(state_q == ST_RD_STROBE); // RULE11
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write data drive
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      data_bus_out      <= '0;
      data_bus_oe_n_out <= 1'b1;
    end else begin
      if (state_q == ST_IDLE && req_valid_in && req_write_in) begin
        data_bus_out <= req_wdata_in;
      end
      // Drive only after the float delay, held through the strobe rise
      data_bus_oe_n_out <= !(state_q == ST_WR_DRIVE || state_q == ST_WR_END); // RULE10 RULE8 RULE9
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Request handshake and read return
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      req_ready_out <= 1'b0;
      rd_valid_out  <= 1'b0;
      rd_data_out   <= '0;
    end else begin
      req_ready_out <= (state_q == ST_IDLE && !req_valid_in)
                       || (state_q == ST_WR_END)
                       || (state_q == ST_RECOVER && cnt_q == '0);
      rd_valid_out  <= 1'b0;
      if (state_q == ST_RD_STROBE && cnt_q == '0) begin
        rd_data_out  <= stable_q; // RULE3 RULE14
        rd_valid_out <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  logic [CNT_W-1:0]  we_low_q;

  // Counts cycles of write strobe low
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      we_low_q <= '0;
    end else if (write_en_n_out) begin
      we_low_q <= '0;
    end else begin
      we_low_q <= we_low_q + 1'b1;
    end
  end

  sequence write_start_s;
    $fell(write_en_n_out) && !select_n_out;
  endsequence

  chk_drive_in_write: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    !data_bus_oe_n_out |-> !select_n_out || $past(!write_en_n_out)) // RULE10
    else $error("data driven outside a write");
  chk_oe_write_excl: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    !out_en_n_out |-> write_en_n_out && data_bus_oe_n_out) // RULE11
    else $error("read enable overlaps write");
  chk_float_before_drive: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    write_start_s |-> data_bus_oe_n_out [*5]) // RULE10
    else $error("data driven before float delay");
  chk_setup_to_end: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    $rose(write_en_n_out) |-> $past(!data_bus_oe_n_out, 6)) // RULE8
    else $error("data setup too short");
  chk_write_length: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    $rose(write_en_n_out) |-> we_low_q == CNT_W'(WRITE_CYC)) // RULE9
    else $error("write strobe length wrong");
  chk_strobes_rise: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    $rose(write_en_n_out) |-> $rose(select_n_out)) // RULE7
    else $error("write not ended by both strobes");
  chk_addr_stable: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    !select_n_out |-> $stable(address_bus_out)) // RULE13
    else $error("address moved while selected");
  chk_hold_after_end: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    $rose(write_en_n_out) |-> !data_bus_oe_n_out ##1 data_bus_oe_n_out) // RULE12
    else $error("data hold wrong");
  chk_read_return: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    $fell(out_en_n_out) |-> ##16 rd_valid_out) // RULE3
    else $error("read data late");
endmodule

// >>> logic/sram_ctrl_pkg.sv
// Constants and types for the asynchronous static memory controller.
// Assumes a 200 MHz system clock; times are in nanoseconds.
package sram_ctrl_pkg;
  localparam int unsigned ADDR_W       = 15;
  localparam int unsigned DATA_W       = 8;
  localparam int unsigned CLK_PERIOD_NS = 5;
  // Slowest speed grade timing, nanoseconds
  localparam int unsigned READ_CYCLE_NS              = 70;
  localparam int unsigned ADDR_TO_DATA_NS            = 70;
  localparam int unsigned SELECT_TO_WRITE_END_NS     = 60;
  localparam int unsigned WRITE_PULSE_NS             = 50;
  localparam int unsigned DATA_SETUP_TO_WRITE_END_NS = 30;
  localparam int unsigned WRITE_STROBE_FLOAT_DELAY_NS = 25;
  localparam int unsigned OUTPUT_FLOAT_NS            = 25;
  // Cycle counts; least times round up
  localparam int unsigned READ_CYC  =
    (ADDR_TO_DATA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned WRITE_CYC =
    (SELECT_TO_WRITE_END_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned FLOAT_CYC =
    (WRITE_STROBE_FLOAT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SETUP_CYC =
    (DATA_SETUP_TO_WRITE_END_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RECOVER_CYC =
    (OUTPUT_FLOAT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W = 5;
  typedef enum logic [2:0] {
    ST_IDLE, ST_RD_STROBE, ST_WR_FLOAT, ST_WR_DRIVE, ST_WR_END, ST_RECOVER
  } ctrl_state_t;
endpackage

// >>> sim/sram_model.sv
// Behavioural 32K x 8 static memory standing behind the controller.
// Assumes the bench resolves the shared data bus from both drive enables.
`timescale 1ns/1ps
module sram_model (
  input  wire logic [sram_ctrl_pkg::ADDR_W-1:0] address_bus_in,
  input  wire logic                             select_n_in,
  input  wire logic                             write_en_n_in,
  input  wire logic                             out_en_n_in,
  input  wire logic [sram_ctrl_pkg::DATA_W-1:0] data_bus_in,
  output logic      [sram_ctrl_pkg::DATA_W-1:0] data_bus_out,
  output logic                                  data_bus_drive_out
);
  import sram_ctrl_pkg::*;
  // Array left unknown until written
  logic [DATA_W-1:0] store [0:(1<<ADDR_W)-1];
  // Drives only when selected, output on, write off
  assign data_bus_drive_out = !select_n_in && !out_en_n_in && write_en_n_in;
  assign data_bus_out = store[address_bus_in];
  // Store only during the strobe overlap
  always @(select_n_in or write_en_n_in or address_bus_in or data_bus_in) begin
    if (!select_n_in && !write_en_n_in) begin
      store[address_bus_in] = data_bus_in;
    end
  end
endmodule

// >>> sim/tb_top.sv
// Self-checking bench for the static memory controller.
// Assumes the memory model sits on the pins and the bench resolves the bus.
`timescale 1ns/1ps
module tb_top;
  import sram_ctrl_pkg::*;
  logic              sys_clk_in, srst_in, req_valid_in, req_write_in;
  logic [ADDR_W-1:0] req_addr_in, address_bus_out, addr_prev;
  logic [DATA_W-1:0] req_wdata_in, rd_data_out, bus_w, bus_q, ctrl_dq, mem_dq, dprev;
  logic              req_ready_out, rd_valid_out, select_n_out, write_en_n_out;
  logic              out_en_n_out, data_bus_oe_n_out, mem_drive, sel_prev, we_prev;
  int                err_total, checks_done, low_cnt;
  sram_ctrl sram_ctrl_inst (.sys_clk_in(sys_clk_in), .srst_in(srst_in),
    .req_valid_in(req_valid_in), .req_write_in(req_write_in), .req_addr_in(req_addr_in),
    .req_wdata_in(req_wdata_in), .req_ready_out(req_ready_out), .rd_valid_out(rd_valid_out),
    .rd_data_out(rd_data_out), .address_bus_out(address_bus_out), .select_n_out(select_n_out),
    .write_en_n_out(write_en_n_out), .out_en_n_out(out_en_n_out), .data_bus_in(bus_w),
    .data_bus_out(ctrl_dq), .data_bus_oe_n_out(data_bus_oe_n_out));
  sram_model sram_model_inst (.address_bus_in(address_bus_out), .select_n_in(select_n_out),
    .write_en_n_in(write_en_n_out), .out_en_n_in(out_en_n_out), .data_bus_in(bus_w),
    .data_bus_out(mem_dq), .data_bus_drive_out(mem_drive));
  // Released bus shows the inverse of its last level
  assign bus_w = !data_bus_oe_n_out ? ctrl_dq : (mem_drive ? mem_dq : ~bus_q);
  always @(posedge sys_clk_in) if (!data_bus_oe_n_out || mem_drive) bus_q <= bus_w;
  initial begin
    sys_clk_in = 1'b0;
    forever #2.5 sys_clk_in = ~sys_clk_in;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Pin monitor, sampled mid-cycle
  always @(negedge sys_clk_in) begin
    if (!srst_in) begin
      chk("bus contention", 0, !data_bus_oe_n_out && mem_drive);
      if (!select_n_out && !sel_prev) chk("address hold", addr_prev, address_bus_out);
      if (write_en_n_out && !we_prev) chk("write span", 1, low_cnt >= FLOAT_CYC + SETUP_CYC);
      if (write_en_n_out && !we_prev) chk("data at write end", {1'b0, dprev}, {data_bus_oe_n_out, ctrl_dq});
    end
    low_cnt = write_en_n_out ? 0 : low_cnt + 1;
    sel_prev = select_n_out;
    we_prev = write_en_n_out;
    addr_prev = address_bus_out;
    dprev = ctrl_dq;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic issue(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    int n;
    for (n = 0; n < 100 && req_ready_out !== 1'b1; n++) @(negedge sys_clk_in);
    if (n >= 100) begin
      err_total++;
      give_verdict();
    end
    @(posedge sys_clk_in);
    req_valid_in <= 1'b1;
    req_write_in <= wr;
    req_addr_in <= a;
    req_wdata_in <= d;
    @(posedge sys_clk_in);
    req_valid_in <= 1'b0;
  endtask
  task automatic do_write(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    int n;
    issue(1'b1, a, d);
    n = 0;
    do begin
      @(negedge sys_clk_in);
      n++;
      if (n == 5) chk("write strobes", 2'b00, {select_n_out, write_en_n_out});
      if (n == 5) chk("write address", {1'b0, a}, {1'b0, address_bus_out});
    end while (req_ready_out !== 1'b1 && n < 100);
    chk("write latency", 16'(WRITE_CYC + 2), n[15:0]);
    if (n >= 100) give_verdict();
  endtask
  task automatic do_read(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    int n;
    issue(1'b0, a, 8'h00);
    n = 0;
    do begin
      @(negedge sys_clk_in);
      n++;
      if (n == 5) chk("read strobes", 3'b001, {select_n_out, out_en_n_out, write_en_n_out});
      if (n == 5) chk("read address", {1'b0, a}, {1'b0, address_bus_out});
    end while (rd_valid_out !== 1'b1 && n < 100);
    chk("read latency", 16'(READ_CYC + 4), n[15:0]);
    chk("read data", {8'h00, exp}, {8'h00, rd_data_out});
    if (n >= 100) give_verdict();
  endtask
  // Request offered mid-write must be dropped
  task automatic busy_ignore();
    issue(1'b1, 15'h0001, 8'h11);
    repeat (4) @(posedge sys_clk_in);
    req_valid_in <= 1'b1;
    req_wdata_in <= 8'hEE;
    @(posedge sys_clk_in);
    req_valid_in <= 1'b0;
    do_read(15'h0001, 8'h11);
  endtask
  // Reset in mid-write returns pins to idle
  task automatic mid_reset();
    issue(1'b1, 15'h0002, 8'h77);
    repeat (3) @(posedge sys_clk_in);
    srst_in <= 1'b1;
    repeat (4) @(posedge sys_clk_in);
    srst_in <= 1'b0;
    @(negedge sys_clk_in);
    chk("reset strobes", 4'hF, {select_n_out, write_en_n_out, out_en_n_out, data_bus_oe_n_out});
    do_write(15'h0003, 8'h96);
    do_read(15'h0003, 8'h96);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    err_total = 0;
    checks_done = 0;
    srst_in = 1'b1;
    req_valid_in = 1'b0;
    req_write_in = 1'b0;
    req_addr_in = 15'h0000;
    req_wdata_in = 8'h00;
    repeat (5) @(posedge sys_clk_in);
    srst_in <= 1'b0;
    @(negedge sys_clk_in);
    chk("idle strobes", 4'hF, {select_n_out, write_en_n_out, out_en_n_out, data_bus_oe_n_out});
    do_write(15'h0000, 8'hA5);
    do_write(15'h7FFF, 8'h3C);
    do_write(15'h0000, 8'h5A);
    do_read(15'h7FFF, 8'h3C);
    do_read(15'h0000, 8'h5A);
    busy_ignore();
    mid_reset();
    give_verdict();
  end
endmodule
